// file: core/setpoint_pkg.sv
// constants for the setpoint selection and start control block
// What this block does
// R1: combined setpoint is selector one output plus selector two output
// R2: separate source selectors for speed and positioning, picked by operating type
// R3: code 0 zero, code 1 analog input zero, code 2 analog input one
// R4: codes 3..6 serial link, slave reference, fieldbus, sequencer
// R5: code 7 travel table, code 8 fixed value
// R6: code 9 minimum value, code 10 maximum value
// R7: code 11 comm module, code 12 settings port
// R8: all setpoints signed and confined to -32764..+32764
// R9: location codes 0 none, 1 terminal, 2 keypad; terminal is default
// R10: location codes 3 serial, 4 fieldbus, 5 comm module, 6 sequencer; 7 settings port, which starts nothing
// R11: commander sets release 10 ms before start, safe stop inactive
// R12: edge mode starts only on a low-to-high start transition
// R13: edge mode ignores a start already high at power-up
// R14: level mode starts whenever start is high, also after power-up
// R15: auto-start off selects edge mode, on selects level mode; default off
// R16: auto-start restarts after mains-on and after permitted error reset
// R17: terminal start from run request, run right or run left; run right and run left set direction
// R18: virtual start with auto-start starts on release alone
// R19: keypad takeover sets location and channel one to keypad, disables channel two
// R20: host session switches location to serial, session end restores previous
// R21: host link loss keeps serial location until changed explicitly
// R22: sequencer control sets location to sequencer code
// R23: sum saturates to setpoint range instead of wrapping
// R24: start requests from non-selected locations are ignored
package setpoint_pkg;
	localparam int SP_W = 16;
	localparam int SUM_W = 17;
	localparam logic signed [SP_W-1:0] SP_MAX = 16'sh7FFC;
	localparam logic signed [SP_W-1:0] SP_MIN = -16'sh7FFC;
	localparam int SRC_W = 4;
	localparam int NSRC = 13;
	localparam int LOC_W = 3;
	localparam int NLOC = 8;

	// source selector codes
	localparam logic [SRC_W-1:0] SRC_ZERO = 4'h0;
	localparam logic [SRC_W-1:0] SRC_ANA0 = 4'h1;
	localparam logic [SRC_W-1:0] SRC_ANA1 = 4'h2;
	localparam logic [SRC_W-1:0] SRC_SERIAL = 4'h3;
	localparam logic [SRC_W-1:0] SRC_SLAVE = 4'h4;
	localparam logic [SRC_W-1:0] SRC_FIELDBUS = 4'h5;
	localparam logic [SRC_W-1:0] SRC_SEQ = 4'h6;
	localparam logic [SRC_W-1:0] SRC_TABLE = 4'h7;
	localparam logic [SRC_W-1:0] SRC_FIXED = 4'h8;
	localparam logic [SRC_W-1:0] SRC_MIN = 4'h9;
	localparam logic [SRC_W-1:0] SRC_MAX = 4'hA;
	localparam logic [SRC_W-1:0] SRC_COMM = 4'hB;
	localparam logic [SRC_W-1:0] SRC_SETTINGS = 4'hC;

	// control location codes
	localparam logic [LOC_W-1:0] LOC_NONE = 3'h0;
	localparam logic [LOC_W-1:0] LOC_TERMINAL = 3'h1;
	localparam logic [LOC_W-1:0] LOC_KEYPAD = 3'h2;
	localparam logic [LOC_W-1:0] LOC_HOST_LINK = 3'h3;
	localparam logic [LOC_W-1:0] LOC_FIELDBUS = 3'h4;
	localparam logic [LOC_W-1:0] LOC_COMM_MODULE = 3'h5;
	localparam logic [LOC_W-1:0] LOC_SEQUENCER = 3'h6;
	localparam logic [LOC_W-1:0] LOC_SETTINGS_PORT = 3'h7;

	// register byte addresses
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_LOCATION = 8'h04;
	localparam logic [7:0] ADDR_SPEED_SRC = 8'h08;
	localparam logic [7:0] ADDR_POS_SRC = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_SETPOINTS = 8'h14;

	// control register fields
	localparam int CTRL_AUTO_BIT = 0;
	localparam int CTRL_VIRTUAL_BIT = 1;
	localparam int CTRL_CH2_OFF_BIT = 2;
	// source register fields: channel one low nibble, channel two next
	localparam int SRC1_LSB = 0;
	localparam int SRC2_LSB = 4;
	// status register fields
	localparam int STAT_ACTIVE_BIT = 0;
	localparam int STAT_LEFT_BIT = 1;
	localparam int STAT_RELEASE_BIT = 2;
	localparam int STAT_SESSION_BIT = 3;
	localparam int STAT_LOC_LSB = 4;

	localparam logic [SRC_W-1:0] SPEED_SRC1_RESET = SRC_ANA0;
	localparam logic [SRC_W-1:0] SPEED_SRC2_RESET = SRC_ZERO;
	localparam logic [SRC_W-1:0] POS_SRC1_RESET = SRC_ANA0;
	localparam logic [SRC_W-1:0] POS_SRC2_RESET = SRC_ZERO;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// release lead time
	localparam int CLK_HZ = 10_000_000;
	localparam int RELEASE_LEAD_MS = 10;
	localparam int RELEASE_LEAD_CYCLES = (RELEASE_LEAD_MS * CLK_HZ + 999) / 1000;
	localparam int REL_CNT_W = 20;
endpackage : setpoint_pkg

// file: core/setpoint_start_ctrl.sv
// setpoint channel selection, summing and start evaluation with AXI4-Lite registers
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module setpoint_start_ctrl #(
	parameter int RELEASE_CYCLES = setpoint_pkg::RELEASE_LEAD_CYCLES
) (
	input  wire logic                              CLK_IN,
	input  wire logic                              RESET_IN,
	input  wire logic                              CE_IN,
	input  wire logic                              POSITION_MODE_IN,
	input  wire logic signed [setpoint_pkg::SP_W-1:0] ANALOG_INPUT_ZERO_IN,
	input  wire logic signed [setpoint_pkg::SP_W-1:0] ANALOG_INPUT_ONE_IN,
	input  wire logic signed [setpoint_pkg::SP_W-1:0] SERIAL_LINK_SOURCE_IN,
	input  wire logic signed [setpoint_pkg::SP_W-1:0] SLAVE_REFERENCE_SOURCE_IN,
	input  wire logic signed [setpoint_pkg::SP_W-1:0] FIELDBUS_SOURCE_IN,
	input  wire logic signed [setpoint_pkg::SP_W-1:0] SEQUENCER_SOURCE_IN,
	input  wire logic signed [setpoint_pkg::SP_W-1:0] TRAVEL_TABLE_SOURCE_IN,
	input  wire logic signed [setpoint_pkg::SP_W-1:0] FIXED_VALUE_SOURCE_IN,
	input  wire logic signed [setpoint_pkg::SP_W-1:0] MINIMUM_VALUE_SOURCE_IN,
	input  wire logic signed [setpoint_pkg::SP_W-1:0] MAXIMUM_VALUE_SOURCE_IN,
	input  wire logic signed [setpoint_pkg::SP_W-1:0] COMM_MODULE_SOURCE_IN,
	input  wire logic signed [setpoint_pkg::SP_W-1:0] SETTINGS_PORT_SOURCE_IN,
	input  wire logic signed [setpoint_pkg::SP_W-1:0] KEYPAD_SOURCE_IN,
	input  wire logic [setpoint_pkg::NLOC-1:0]     START_REQ_IN,
	input  wire logic                              RUN_RIGHT_INPUT_IN,
	input  wire logic                              RUN_LEFT_INPUT_IN,
	input  wire logic                              POWER_STAGE_RELEASE_IN,
	input  wire logic                              SAFE_STOP_IN,
	input  wire logic                              ERROR_IN,
	input  wire logic                              ERROR_RESET_IN,
	input  wire logic                              ERROR_RESTART_OK_IN,
	input  wire logic                              KEYPAD_TAKEOVER_IN,
	input  wire logic                              KEYPAD_RELEASE_IN,
	input  wire logic                              HOST_SESSION_START_IN,
	input  wire logic                              HOST_SESSION_END_IN,
	input  wire logic                              SEQUENCER_TAKEOVER_IN,
	output logic signed [setpoint_pkg::SP_W-1:0]   SELECTOR_ONE_OUT,
	output logic signed [setpoint_pkg::SP_W-1:0]   SELECTOR_TWO_OUT,
	output logic signed [setpoint_pkg::SP_W-1:0]   COMBINED_SETPOINT_OUT,
	output logic                                   CONTROL_ACTIVE_OUT,
	output logic                                   DIRECTION_LEFT_OUT,
	input  wire logic [7:0]                        AWADDR,
	input  wire logic                              AWVALID,
	output logic                                   AWREADY,
	input  wire logic [31:0]                       WDATA,
	input  wire logic [3:0]                        WSTRB,
	input  wire logic                              WVALID,
	output logic                                   WREADY,
	output logic [1:0]                             BRESP,
	output logic                                   BVALID,
	input  wire logic                              BREADY,
	input  wire logic [7:0]                        ARADDR,
	input  wire logic                              ARVALID,
	output logic                                   ARREADY,
	output logic [31:0]                            RDATA,
	output logic [1:0]                             RRESP,
	output logic                                   RVALID,
	input  wire logic                              RREADY
);
	import setpoint_pkg::*;

	typedef logic signed [SP_W-1:0] sp_t;

	logic             auto_start_reg;
	logic             virtual_start_reg;
	logic             ch2_off_reg;
	logic [LOC_W-1:0] location_reg;
	logic [LOC_W-1:0] saved_location_reg;
	logic             session_reg;
	logic [SRC_W-1:0] speed_src1_reg;
	logic [SRC_W-1:0] speed_src2_reg;
	logic [SRC_W-1:0] pos_src1_reg;
	logic [SRC_W-1:0] pos_src2_reg;
	logic             keypad_sel_reg;
	logic [REL_CNT_W-1:0] release_cnt_reg;
	logic             release_ok_reg;
	logic             start_prev_reg;
	logic             restart_block_reg;
	logic             aw_held_reg;
	logic             w_held_reg;
	logic [7:0]       aw_addr_reg;
	logic [31:0]      w_data_reg;
	logic [3:0]       w_strb_reg;

	sp_t              src_vec [NSRC];
	sp_t              sel_one;
	sp_t              sel_two;
	logic [SRC_W-1:0] code_one;
	logic [SRC_W-1:0] code_two;
	logic signed [SUM_W-1:0] sum_wide;
	sp_t              sum_sat;
	logic             start_level;
	logic             start_go;
	logic             permit;
	logic             wr_fire;
	logic             wr_hit;
	logic [31:0]      rd_word;
	logic             rd_hit;

	// selected inputs outside the range are pulled in before summing
	function automatic sp_t clamp_sp(input sp_t v);
		if (v > SP_MAX) begin
			return SP_MAX;
		end else if (v < SP_MIN) begin
			return SP_MIN;
		end
		return v;
	endfunction : clamp_sp

	assign src_vec[SRC_ZERO]     = '0; // R3
	assign src_vec[SRC_ANA0]     = ANALOG_INPUT_ZERO_IN; // R3
	assign src_vec[SRC_ANA1]     = ANALOG_INPUT_ONE_IN; // R3
	assign src_vec[SRC_SERIAL]   = SERIAL_LINK_SOURCE_IN; // R4
	assign src_vec[SRC_SLAVE]    = SLAVE_REFERENCE_SOURCE_IN; // R4
	assign src_vec[SRC_FIELDBUS] = FIELDBUS_SOURCE_IN; // R4
	assign src_vec[SRC_SEQ]      = SEQUENCER_SOURCE_IN; // R4
	assign src_vec[SRC_TABLE]    = TRAVEL_TABLE_SOURCE_IN; // R5
	assign src_vec[SRC_FIXED]    = FIXED_VALUE_SOURCE_IN; // R5
	assign src_vec[SRC_MIN]      = MINIMUM_VALUE_SOURCE_IN; // R6
	assign src_vec[SRC_MAX]      = MAXIMUM_VALUE_SOURCE_IN; // R6
	assign src_vec[SRC_COMM]     = COMM_MODULE_SOURCE_IN; // R7
	assign src_vec[SRC_SETTINGS] = SETTINGS_PORT_SOURCE_IN; // R7

	// operating type picks which selector pair is live
	assign code_one = POSITION_MODE_IN ? pos_src1_reg : speed_src1_reg; // R2
	assign code_two = POSITION_MODE_IN ? pos_src2_reg : speed_src2_reg; // R2

	always_comb begin
		// codes 13..15 are unused and behave as zero
		sel_one = '0;
		sel_two = '0;
		if (keypad_sel_reg) begin
			sel_one = clamp_sp(KEYPAD_SOURCE_IN); // R19
		end else if (code_one < SRC_W'(NSRC)) begin
			sel_one = clamp_sp(src_vec[code_one]); // R8
		end
		if (!keypad_sel_reg && !ch2_off_reg && code_two < SRC_W'(NSRC)) begin
			sel_two = clamp_sp(src_vec[code_two]); // R8
		end
	end

	assign sum_wide = SUM_W'(sel_one) + SUM_W'(sel_two); // R1
	always_comb begin
		if (sum_wide > SUM_W'(SP_MAX)) begin
			sum_sat = SP_MAX; // R23
		end else if (sum_wide < SUM_W'(SP_MIN)) begin
			sum_sat = SP_MIN; // R23
		end else begin
			sum_sat = sum_wide[SP_W-1:0];
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			SELECTOR_ONE_OUT      <= '0;
			SELECTOR_TWO_OUT      <= '0;
			COMBINED_SETPOINT_OUT <= '0;
		end else if (CE_IN) begin
			SELECTOR_ONE_OUT      <= sel_one;
			SELECTOR_TWO_OUT      <= sel_two;
			COMBINED_SETPOINT_OUT <= sum_sat; // R1
		end
	end

	// release must stand for the lead time before a start counts
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			release_cnt_reg <= '0;
			release_ok_reg  <= 1'b0;
		end else if (CE_IN) begin
			if (!POWER_STAGE_RELEASE_IN) begin
				release_cnt_reg <= '0;
				release_ok_reg  <= 1'b0;
			end else if (release_cnt_reg >= REL_CNT_W'(RELEASE_CYCLES - 1)) begin
				release_ok_reg <= 1'b1; // R11
			end else begin
				release_cnt_reg <= release_cnt_reg + 1'b1;
			end
		end
	end

	// only the selected location feeds the start evaluation
	always_comb begin
		start_level = 1'b0;
		case (location_reg)
			LOC_TERMINAL: begin
				start_level = START_REQ_IN[LOC_TERMINAL] | RUN_RIGHT_INPUT_IN
					| RUN_LEFT_INPUT_IN; // R17
				if (virtual_start_reg && auto_start_reg) begin
					start_level = 1'b1; // R18
				end
			end
			LOC_NONE, LOC_SETTINGS_PORT: start_level = 1'b0; // R10
			default: start_level = START_REQ_IN[location_reg]; // R24
		endcase
	end

	assign permit   = release_ok_reg && !SAFE_STOP_IN && !ERROR_IN; // R11
	assign start_go = auto_start_reg ? (start_level && !restart_block_reg) // R14 R16
		: (start_level && !start_prev_reg); // R12

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			// held high so a start already present after power-up is no edge
			start_prev_reg    <= 1'b1; // R13
			restart_block_reg <= 1'b0;
		end else if (CE_IN) begin
			start_prev_reg <= start_level;
			// reset without restart leave keeps auto start off until start drops
			if (ERROR_RESET_IN && !ERROR_RESTART_OK_IN) begin
				restart_block_reg <= 1'b1; // R16
			end else if (!start_level) begin
				restart_block_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			CONTROL_ACTIVE_OUT <= 1'b0;
		end else if (CE_IN) begin
			if (!permit || !start_level) begin
				CONTROL_ACTIVE_OUT <= 1'b0;
			end else if (start_go) begin
				CONTROL_ACTIVE_OUT <= 1'b1; // R15
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			DIRECTION_LEFT_OUT <= 1'b0;
		end else if (CE_IN && location_reg == LOC_TERMINAL) begin
			if (RUN_LEFT_INPUT_IN && !RUN_RIGHT_INPUT_IN) begin
				DIRECTION_LEFT_OUT <= 1'b1; // R17
			end else if (RUN_RIGHT_INPUT_IN && !RUN_LEFT_INPUT_IN) begin
				DIRECTION_LEFT_OUT <= 1'b0; // R17
			end
		end
	end

	// register write path; address and data may come in either order
	assign wr_fire = aw_held_reg && w_held_reg && !BVALID;
	assign wr_hit  = wr_fire && w_strb_reg[0];

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= '0;
			w_strb_reg  <= '0;
			AWREADY     <= 1'b0;
			WREADY      <= 1'b0;
			BVALID      <= 1'b0;
			BRESP       <= RESP_OKAY;
		end else if (CE_IN) begin
			AWREADY <= !aw_held_reg && !AWREADY && !BVALID;
			WREADY  <= !w_held_reg && !WREADY && !BVALID;
			if (AWVALID && AWREADY) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_held_reg <= 1'b1;
				w_data_reg <= WDATA;
				w_strb_reg <= WSTRB;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				BVALID      <= 1'b1;
				BRESP       <= (aw_addr_reg <= ADDR_POS_SRC) ? RESP_OKAY : RESP_SLVERR;
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			auto_start_reg    <= 1'b0; // R15
			virtual_start_reg <= 1'b0;
			ch2_off_reg       <= 1'b0;
			speed_src1_reg    <= SPEED_SRC1_RESET;
			speed_src2_reg    <= SPEED_SRC2_RESET;
			pos_src1_reg      <= POS_SRC1_RESET;
			pos_src2_reg      <= POS_SRC2_RESET;
		end else if (CE_IN) begin
			if (KEYPAD_TAKEOVER_IN) begin
				ch2_off_reg <= 1'b1; // R19
			end else if (wr_hit) begin
				case (aw_addr_reg)
					ADDR_CONTROL: begin
						auto_start_reg    <= w_data_reg[CTRL_AUTO_BIT];
						virtual_start_reg <= w_data_reg[CTRL_VIRTUAL_BIT];
						ch2_off_reg       <= w_data_reg[CTRL_CH2_OFF_BIT];
					end
					ADDR_SPEED_SRC: begin
						speed_src1_reg <= w_data_reg[SRC1_LSB +: SRC_W];
						speed_src2_reg <= w_data_reg[SRC2_LSB +: SRC_W];
					end
					ADDR_POS_SRC: begin
						pos_src1_reg <= w_data_reg[SRC1_LSB +: SRC_W];
						pos_src2_reg <= w_data_reg[SRC2_LSB +: SRC_W];
					end
					default: ;
				endcase
			end
		end
	end

	// location: takeovers beat software writes
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			location_reg       <= LOC_TERMINAL; // R9
			saved_location_reg <= LOC_TERMINAL;
			session_reg        <= 1'b0;
			keypad_sel_reg     <= 1'b0;
		end else if (CE_IN) begin
			if (KEYPAD_TAKEOVER_IN) begin
				location_reg   <= LOC_KEYPAD; // R19
				keypad_sel_reg <= 1'b1; // R19
			end else if (HOST_SESSION_START_IN && !session_reg) begin
				saved_location_reg <= location_reg;
				location_reg       <= LOC_HOST_LINK; // R20
				session_reg        <= 1'b1;
			end else if (HOST_SESSION_END_IN && session_reg) begin
				location_reg <= saved_location_reg; // R20
				session_reg  <= 1'b0;
			end else if (SEQUENCER_TAKEOVER_IN) begin
				location_reg <= LOC_SEQUENCER; // R22
			end else if (wr_hit && aw_addr_reg == ADDR_LOCATION) begin
				// a lost host link leaves serial in place until written here
				location_reg <= w_data_reg[LOC_W-1:0]; // R21
				session_reg  <= 1'b0;
			end
			if (KEYPAD_RELEASE_IN && !KEYPAD_TAKEOVER_IN) begin
				keypad_sel_reg <= 1'b0;
			end
		end
	end

	// read path
	always_comb begin
		rd_word = '0;
		rd_hit  = 1'b1;
		case (ARADDR)
			ADDR_CONTROL: begin
				rd_word[CTRL_AUTO_BIT]    = auto_start_reg;
				rd_word[CTRL_VIRTUAL_BIT] = virtual_start_reg;
				rd_word[CTRL_CH2_OFF_BIT] = ch2_off_reg;
			end
			ADDR_LOCATION: rd_word[LOC_W-1:0] = location_reg;
			ADDR_SPEED_SRC: begin
				rd_word[SRC1_LSB +: SRC_W] = speed_src1_reg;
				rd_word[SRC2_LSB +: SRC_W] = speed_src2_reg;
			end
			ADDR_POS_SRC: begin
				rd_word[SRC1_LSB +: SRC_W] = pos_src1_reg;
				rd_word[SRC2_LSB +: SRC_W] = pos_src2_reg;
			end
			ADDR_STATUS: begin
				rd_word[STAT_ACTIVE_BIT]  = CONTROL_ACTIVE_OUT;
				rd_word[STAT_LEFT_BIT]    = DIRECTION_LEFT_OUT;
				rd_word[STAT_RELEASE_BIT] = release_ok_reg;
				rd_word[STAT_SESSION_BIT] = session_reg;
				rd_word[STAT_LOC_LSB +: LOC_W] = location_reg;
			end
			ADDR_SETPOINTS: begin
				rd_word[SP_W-1:0]  = COMBINED_SETPOINT_OUT;
				rd_word[31:SP_W]   = SELECTOR_ONE_OUT;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= '0;
			RRESP   <= RESP_OKAY;
		end else if (CE_IN) begin
			ARREADY <= !ARREADY && !RVALID && ARVALID;
			if (ARVALID && ARREADY) begin
				RVALID <= 1'b1;
				RDATA  <= rd_word;
				RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (RVALID && RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end
endmodule : setpoint_start_ctrl

// file: verification/setpoint_start_ctrl_props.sv
// checker for setpoint limits, start gating and register handshakes
`timescale 1ns/10ps
module setpoint_start_ctrl_props #(
	parameter int RELEASE_CYCLES = 8
) (
	input wire logic					CLK_IN,
	input wire logic					RESET_IN,
	input wire logic					POWER_STAGE_RELEASE_IN,
	input wire logic					SAFE_STOP_IN,
	input wire logic					ERROR_IN,
	input wire logic signed [setpoint_pkg::SP_W-1:0]	SELECTOR_ONE_OUT,
	input wire logic signed [setpoint_pkg::SP_W-1:0]	COMBINED_SETPOINT_OUT,
	input wire logic					CONTROL_ACTIVE_OUT,
	input wire logic					AWREADY,
	input wire logic					ARVALID,
	input wire logic					ARREADY,
	input wire logic					RVALID
);
	import setpoint_pkg::*;
	logic [REL_CNT_W-1:0]	rel_cnt_reg;
	// saturating run length of the release input
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN || !POWER_STAGE_RELEASE_IN)
			rel_cnt_reg <= '0;
		else if (!(&rel_cnt_reg))
			rel_cnt_reg <= rel_cnt_reg + 1'h1;
	end
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);
	sum_range_a: assert property (COMBINED_SETPOINT_OUT >= SP_MIN && COMBINED_SETPOINT_OUT <= SP_MAX)
		else $error("combined setpoint out of range");
	sel_range_a: assert property (SELECTOR_ONE_OUT >= SP_MIN && SELECTOR_ONE_OUT <= SP_MAX)
		else $error("selector one out of range");
	stop_blocks_a: assert property (SAFE_STOP_IN |=> !CONTROL_ACTIVE_OUT)
		else $error("active during safe stop");
	error_blocks_a: assert property (ERROR_IN |=> !CONTROL_ACTIVE_OUT)
		else $error("active during error");
	release_drop_a: assert property (!POWER_STAGE_RELEASE_IN |-> ##2 !CONTROL_ACTIVE_OUT)
		else $error("active without release");
	release_lead_a: assert property ($rose(CONTROL_ACTIVE_OUT) |-> rel_cnt_reg >= RELEASE_CYCLES)
		else $error("start before release lead time");
	read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read answer late");
	ready_pulse_a: assert property (AWREADY |=> !AWREADY)
		else $error("write address ready held");
endmodule : setpoint_start_ctrl_props

bind setpoint_start_ctrl setpoint_start_ctrl_props #(.RELEASE_CYCLES(RELEASE_CYCLES))
	setpoint_start_ctrl_props_inst (.*);

// file: verification/commander_model.sv
// commanding party: raises release, then start once the lead time is over
`timescale 1ns/10ps
module commander_model #(
	parameter int LEAD = 8
) (
	input  wire logic	clk_in,
	input  wire logic	run_in,
	input  wire logic	start_en_in,
	output logic		release_out,
	output logic		start_out
);
	int cnt = 0;
	initial release_out = 1'h0;
	initial start_out = 1'h0;
	// margin past the lead so start never races the release qualification
	always @(posedge clk_in) begin
		release_out <= run_in;
		cnt <= run_in ? (cnt < LEAD + 6 ? cnt + 1 : cnt) : 0;
		start_out <= start_en_in && run_in && cnt >= LEAD + 4;
	end
endmodule : commander_model

// file: verification/setpoint_start_ctrl_test.sv
// self-checking bench for setpoint selection and start control
`timescale 1ns/10ps
module setpoint_start_ctrl_test;
	import setpoint_pkg::*;
	localparam int RC = 8;
	logic CLK_IN = 1'h0, RESET_IN = 1'h1, POSITION_MODE_IN = 1'h0;
	logic RUN_RIGHT_INPUT_IN = 1'h0, RUN_LEFT_INPUT_IN = 1'h0, SAFE_STOP_IN = 1'h0;
	logic ERROR_IN = 1'h0, ERROR_RESET_IN = 1'h0, ERROR_RESTART_OK_IN = 1'h0;
	logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
	logic run = 1'h0, start_en = 1'h1, rel, cmd_start;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CONTROL_ACTIVE_OUT, DIRECTION_LEFT_OUT;
	logic [4:0]		pz = 5'h0;
	logic [7:0]		AWADDR = 8'h0, ARADDR = 8'h0, start_req = 8'h02;
	logic [31:0]		WDATA = 32'h0, RDATA, rv;
	logic [3:0]		WSTRB = 4'hF;
	logic [1:0]		BRESP, RRESP;
	logic signed [15:0]	KEYPAD_SOURCE_IN = 16'h0, src [13] = '{default: 16'h0};
	logic signed [15:0]	SELECTOR_ONE_OUT, SELECTOR_TWO_OUT, COMBINED_SETPOINT_OUT;
	int fails = 0, total_checks = 0, cyc = 0;

	setpoint_start_ctrl #(.RELEASE_CYCLES(RC)) setpoint_start_ctrl_inst (.*, .CE_IN(1'h1),
		.ANALOG_INPUT_ZERO_IN(src[1]), .ANALOG_INPUT_ONE_IN(src[2]), .SERIAL_LINK_SOURCE_IN(src[3]),
		.SLAVE_REFERENCE_SOURCE_IN(src[4]), .FIELDBUS_SOURCE_IN(src[5]), .SEQUENCER_SOURCE_IN(src[6]),
		.TRAVEL_TABLE_SOURCE_IN(src[7]), .FIXED_VALUE_SOURCE_IN(src[8]),
		.MINIMUM_VALUE_SOURCE_IN(src[9]), .MAXIMUM_VALUE_SOURCE_IN(src[10]),
		.COMM_MODULE_SOURCE_IN(src[11]), .SETTINGS_PORT_SOURCE_IN(src[12]),
		.KEYPAD_TAKEOVER_IN(pz[0]), .KEYPAD_RELEASE_IN(pz[1]), .HOST_SESSION_START_IN(pz[2]),
		.HOST_SESSION_END_IN(pz[3]), .SEQUENCER_TAKEOVER_IN(pz[4]),
		.START_REQ_IN(start_req | {6'h0, cmd_start, 1'h0}), .POWER_STAGE_RELEASE_IN(rel));
	commander_model #(.LEAD(RC)) commander_model_inst (.clk_in(CLK_IN), .run_in(run),
		.start_en_in(start_en), .release_out(rel), .start_out(cmd_start));

	initial forever #50 CLK_IN = ~CLK_IN;

	function automatic logic signed [15:0] lim(input int v);
		return v > 32764 ? SP_MAX : (v < -32764 ? SP_MIN : 16'(v));
	endfunction : lim
	function automatic logic signed [15:0] pick(input int c);
		return c == 0 ? 16'sh0 : lim(src[c]);
	endfunction : pick
	task automatic tick(input int n);
		repeat (n) @(posedge CLK_IN);
	endtask : tick
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 1'h0;
		w = 1'h0;
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'h1;
		WVALID <= 1'h1;
		BREADY <= 1'h1;
		while (!(aw && w)) begin
			@(posedge CLK_IN);
			aw = aw | AWREADY;
			w = w | WREADY;
			AWVALID <= !aw;
			WVALID <= !w;
		end
		do @(posedge CLK_IN); while (BVALID !== 1'h1);
		BREADY <= 1'h0;
		chk(BRESP, er);
		@(posedge CLK_IN);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		ARADDR <= a;
		ARVALID <= 1'h1;
		RREADY <= 1'h1;
		do @(posedge CLK_IN); while (ARREADY !== 1'h1);
		ARVALID <= 1'h0;
		while (RVALID !== 1'h1) @(posedge CLK_IN);
		RREADY <= 1'h0;
		rv = RDATA;
		chk(RRESP, er);
		@(posedge CLK_IN);
	endtask : rd
	// pulse one takeover, release or session input, then read back the location
	task automatic pul(input int k, input logic [2:0] e);
		pz <= 5'h1 << k;
		tick(1);
		pz <= 5'h0;
		tick(3);
		rd(ADDR_STATUS, RESP_OKAY);
		chk(rv[6:4], e);
	endtask : pul
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	always @(posedge CLK_IN) begin
		cyc++;
		if (cyc == 6000) begin
			fails++;
			wrap_up();
		end
	end

	initial begin
		void'($urandom(21));
		tick(4);
		RESET_IN <= 1'h0;
		tick(1);
		rd(ADDR_CONTROL, RESP_OKAY);
		chk(rv, 32'h0);
		rd(ADDR_LOCATION, RESP_OKAY);
		chk(rv[2:0], LOC_TERMINAL);
		rd(8'h18, RESP_SLVERR);
		wr(ADDR_STATUS, 32'h0, RESP_SLVERR);
		// extremes on codes 1 and 10 push the sum into saturation
		foreach (src[i]) src[i] <= (i == 1) ? 16'sh7530 : ((i == 10) ? 16'sh7FFF : 16'($urandom));
		KEYPAD_SOURCE_IN <= 16'($urandom);
		for (int c = 0; c < 13; c++) begin
			wr(ADDR_SPEED_SRC, 32'(c), RESP_OKAY);
			tick(2);
			chk(SELECTOR_ONE_OUT, pick(c));
		end
		for (int c = 0; c < 13; c++) begin
			wr(ADDR_SPEED_SRC, 32'(c * 16 + 1), RESP_OKAY);
			tick(2);
			chk(SELECTOR_TWO_OUT, pick(c));
			chk(COMBINED_SETPOINT_OUT, lim(pick(1) + pick(c)));
		end
		wr(ADDR_POS_SRC, 32'h2, RESP_OKAY);
		POSITION_MODE_IN <= 1'h1;
		tick(3);
		chk(SELECTOR_ONE_OUT, pick(2));
		POSITION_MODE_IN <= 1'h0;
		tick(3);
		chk(SELECTOR_ONE_OUT, pick(1));
		run <= 1'h1;
		tick(RC + 12);
		chk(CONTROL_ACTIVE_OUT, 1'h0);
		start_req <= 8'h0;
		start_en <= 1'h0;
		tick(3);
		start_req <= 8'h10;
		tick(3);
		chk(CONTROL_ACTIVE_OUT, 1'h0);
		start_req <= 8'h0;
		start_en <= 1'h1;
		run <= 1'h0;
		tick(3);
		run <= 1'h1;
		tick(RC + 12);
		chk(CONTROL_ACTIVE_OUT, 1'h1);
		SAFE_STOP_IN <= 1'h1;
		tick(2);
		chk(CONTROL_ACTIVE_OUT, 1'h0);
		SAFE_STOP_IN <= 1'h0;
		tick(3);
		chk(CONTROL_ACTIVE_OUT, 1'h0);
		wr(ADDR_CONTROL, 32'h1, RESP_OKAY);
		tick(3);
		chk(CONTROL_ACTIVE_OUT, 1'h1);
		ERROR_IN <= 1'h1;
		RUN_LEFT_INPUT_IN <= 1'h1;
		tick(2);
		chk(CONTROL_ACTIVE_OUT, 1'h0);
		ERROR_IN <= 1'h0;
		ERROR_RESET_IN <= 1'h1;
		ERROR_RESTART_OK_IN <= 1'h1;
		tick(1);
		ERROR_RESET_IN <= 1'h0;
		tick(3);
		chk(CONTROL_ACTIVE_OUT, 1'h1);
		chk(DIRECTION_LEFT_OUT, 1'h1);
		ERROR_IN <= 1'h1;
		ERROR_RESET_IN <= 1'h1;
		ERROR_RESTART_OK_IN <= 1'h0;
		RUN_LEFT_INPUT_IN <= 1'h0;
		RUN_RIGHT_INPUT_IN <= 1'h1;
		tick(2);
		ERROR_IN <= 1'h0;
		ERROR_RESET_IN <= 1'h0;
		tick(3);
		chk(DIRECTION_LEFT_OUT, 1'h0);
		chk(CONTROL_ACTIVE_OUT, 1'h0);
		RUN_RIGHT_INPUT_IN <= 1'h0;
		start_en <= 1'h0;
		run <= 1'h0;
		wr(ADDR_CONTROL, 32'h3, RESP_OKAY);
		chk(CONTROL_ACTIVE_OUT, 1'h0);
		run <= 1'h1;
		tick(RC + 12);
		chk(CONTROL_ACTIVE_OUT, 1'h1);
		pul(0, LOC_KEYPAD);
		chk(COMBINED_SETPOINT_OUT, lim(KEYPAD_SOURCE_IN));
		rd(ADDR_CONTROL, RESP_OKAY);
		chk(rv[2], 1'h1);
		pul(1, LOC_KEYPAD);
		chk(SELECTOR_ONE_OUT, pick(1));
		pul(2, LOC_HOST_LINK);
		chk(rv[3], 1'h1);
		pul(3, LOC_KEYPAD);
		pul(2, LOC_HOST_LINK);
		tick(20);
		rd(ADDR_STATUS, RESP_OKAY);
		chk(rv[6:4], LOC_HOST_LINK);
		pul(4, LOC_SEQUENCER);
		wr(ADDR_LOCATION, 32'(LOC_FIELDBUS), RESP_OKAY);
		rd(ADDR_STATUS, RESP_OKAY);
		chk(rv[6:4], LOC_FIELDBUS);
		start_req <= 8'h90;
		tick(3);
		chk(CONTROL_ACTIVE_OUT, 1'h1);
		wr(ADDR_LOCATION, 32'(LOC_SETTINGS_PORT), RESP_OKAY);
		tick(2);
		chk(CONTROL_ACTIVE_OUT, 1'h0);
		wrap_up();
	end
endmodule : setpoint_start_ctrl_test
